//--- rtl/fpga_config_loader.v
/*
 Configuration loader: fills the configuration memory from a serial flash
 (active), an external master (passive) or the test port (jtag).
 Assumes all pins are asynchronous to core_clk and much slower than it.
*/
// Notes on behaviour
// - User logic stays held until the whole image sits in configuration memory.
// - This block alone loads the configuration memory and sequences the whole load.
// - A rising edge on the synchronised reset pin, after it was low, starts a load.
// - In active mode the loader begins every flash transfer itself.
// - In active mode the flash clock is divided down from the core clock.
// - In active mode the loader shifts out both instruction and address.
// - The first active transfer is the wake instruction.
// - After wake the select stays high for at least 30 us.
// - Then a fast read from address zero with a 24-bit address follows.
// - In passive mode an external master gives select, clock and data.
// - The test port can also load the full image one bit per clock.
`timescale 1ns/1ns
`include "config_loader_map.vh"
`default_nettype none
module fpga_config_loader #(
   parameter IMAGE_WORDS = 16                // Words in one image.
) (
   input  wire        core_clk,              // Core clock, 10 MHz.
   input  wire        rst_b,                 // Asynchronous reset, active low.
   input  wire        config_reset_low_pin,  // Configuration reset pin, active low.
   input  wire [1:0]  mode_pin,              // Load mode straps.
   input  wire [2:0]  width_pin,             // Passive width select, 2**n bits, 32 bits for n above 5.
   output reg         spi_clk_o,             // Flash clock.
   output reg         spi_cs_b,              // Flash select, active low.
   output reg         spi_mosi,              // Flash serial data out.
   output reg         spi_oe,                // High while flash pins are driven.
   input  wire        spi_miso,              // Flash serial data in.
   input  wire        passive_clk,           // Clock from external master.
   input  wire        passive_cs_b,          // Select from external master.
   input  wire [31:0] passive_data,          // Data bus from external master.
   input  wire        jtag_tck,              // Test clock.
   input  wire        jtag_tdi,              // Test data in.
   input  wire        jtag_load,             // Test port load enable.
   output reg  [31:0] cfg_mem_data,          // Word for configuration memory.
   output reg  [15:0] cfg_mem_addr,          // Word address.
   output reg         cfg_mem_valid,         // Word offered.
   input  wire        cfg_mem_ready,         // Memory takes the word.
   output reg         overrun_reg,           // Word lost in a mode that cannot stall.
   output reg         user_release           // User logic released.
);
   localparam ST_IDLE = 3'd0, ST_WAKE = 3'd1, ST_GAP = 3'd2, ST_HDR = 3'd3;
   localparam ST_READ = 3'd4, ST_PASV = 3'd5, ST_JTAG = 3'd6, ST_DONE = 3'd7;
   localparam [8:0] GAP_CYC = `WAKE_GAP_CYC;
   localparam [2:0] HALF    = `SPI_HALF_CYC - 1;
   localparam [7:0] WAKE_CMD = `CMD_WAKE;

   // Appends 2**wsel bits, first bit most significant, to the word in progress.
   function [31:0] pack;
      input [31:0] word;
      input [31:0] bits;
      input [2:0]  wsel;
      begin
         case (wsel)
            3'd0:    pack = {word[30:0], bits[0]};
            3'd1:    pack = {word[29:0], bits[1:0]};
            3'd2:    pack = {word[27:0], bits[3:0]};
            3'd3:    pack = {word[23:0], bits[7:0]};
            3'd4:    pack = {word[15:0], bits[15:0]};
            default: pack = bits;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg [39:0] s1_reg, s2_reg;
   reg        pclk3_reg, tck3_reg, rpin3_reg;
   wire [39:0] pins = {passive_data, config_reset_low_pin, spi_miso, passive_clk,
                       passive_cs_b, jtag_tck, jtag_tdi, jtag_load, 1'b0};

   // Two flops on every pin except the mode and width straps; the third stage only feeds edge detection.
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_reg    <= 40'h0;
         s2_reg    <= 40'h0;
         pclk3_reg <= 1'b0;
         tck3_reg  <= 1'b0;
         rpin3_reg <= 1'b0;
      end else begin
         s1_reg    <= pins;
         s2_reg    <= s1_reg;
         pclk3_reg <= s2_reg[5];
         tck3_reg  <= s2_reg[3];
         rpin3_reg <= s2_reg[7];
      end
   end
   wire [31:0] pdata_s = s2_reg[39:8];
   wire        rpin_s  = s2_reg[7];
   wire        miso_s  = s2_reg[6];
   wire        pcs_b_s = s2_reg[4];
   wire        tdi_s   = s2_reg[2];
   wire        tload_s = s2_reg[1];
   wire        start   = rpin_s & ~rpin3_reg;
   wire        p_rise  = s2_reg[5] & ~pclk3_reg;
   wire        t_rise  = s2_reg[3] & ~tck3_reg;

   // ----------------------------------------
   // Sequencer and flash shifter
   // ----------------------------------------
   reg [2:0]  state_reg;
   reg [2:0]  div_reg;
   reg [8:0]  gap_reg;
   reg [5:0]  nbit_reg;
   reg [39:0] sh_reg;
   reg [1:0]  mode_reg;
   reg [2:0]  wsel_reg;
   reg [31:0] asm_reg;
   reg [5:0]  fill_reg;
   reg        word_valid_reg;
   reg [15:0] words_in_reg;
   wire       buf_ready;

   // Active mode pauses its clock while a finished word waits for room.
   wire stall    = word_valid_reg & ~buf_ready;
   wire spi_run  = (state_reg == ST_WAKE || state_reg == ST_HDR || state_reg == ST_READ) & ~stall;
   wire tick     = spi_run & (div_reg == HALF);
   wire fall     = tick & spi_clk_o;
   wire [5:0] wbits = 6'd1 << ((state_reg == ST_PASV) ? wsel_reg : 3'd0);
   wire       take  = (state_reg == ST_READ & fall) |
                      (state_reg == ST_PASV & p_rise & ~pcs_b_s) |
                      (state_reg == ST_JTAG & t_rise & tload_s);
   wire [31:0] take_bits = (state_reg == ST_PASV) ? pdata_s :
                           {31'h0, (state_reg == ST_READ) ? miso_s : tdi_s};
   wire       full_word = (fill_reg + wbits) >= 6'd32;
   wire       all_in    = (words_in_reg == IMAGE_WORDS[15:0]);

   // Mode and width are caught on the cycle the start edge is seen.
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg    <= ST_IDLE;
         div_reg      <= 3'h0;
         gap_reg      <= 9'h0;
         nbit_reg     <= 6'h0;
         sh_reg       <= 40'h0;
         mode_reg     <= 2'h0;
         wsel_reg     <= 3'h0;
         spi_clk_o    <= 1'b0;
         spi_cs_b     <= 1'b1;
         spi_mosi     <= 1'b0;
         spi_oe       <= 1'b0;
         user_release <= 1'b0;
      end else begin
         div_reg <= spi_run ? ((div_reg == HALF) ? 3'h0 : div_reg + 3'h1) : 3'h0;
         if (tick)
            spi_clk_o <= ~spi_clk_o;
         if (!rpin_s) begin
            // Reset pin low aborts any load and holds user logic.
            state_reg    <= ST_IDLE;
            user_release <= 1'b0;
            spi_oe       <= 1'b0;
            spi_cs_b     <= 1'b1;
            spi_clk_o    <= 1'b0;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  if (start) begin
                     mode_reg <= mode_pin;
                     wsel_reg <= (width_pin > 3'd5) ? 3'd5 : width_pin;
                     if (mode_pin == `MODE_PASSIVE)
                        state_reg <= ST_PASV;
                     else if (mode_pin == `MODE_JTAG)
                        state_reg <= ST_JTAG;
                     else begin
                        // Wake goes out first, most significant bit first.
                        sh_reg    <= {`CMD_WAKE, 32'h0};
                        spi_mosi  <= WAKE_CMD[7];
                        spi_cs_b  <= 1'b0;
                        spi_oe    <= 1'b1;
                        nbit_reg  <= 6'h0;
                        state_reg <= ST_WAKE;
                     end
                  end
               end
               ST_WAKE, ST_HDR: begin
                  if (fall) begin
                     sh_reg   <= {sh_reg[38:0], 1'b0};
                     spi_mosi <= sh_reg[38];
                     nbit_reg <= nbit_reg + 6'h1;
                     if (state_reg == ST_WAKE && nbit_reg == `WAKE_BITS - 6'h1) begin
                        spi_cs_b  <= 1'b1;
                        gap_reg   <= 9'h0;
                        state_reg <= ST_GAP;
                     end
                     if (state_reg == ST_HDR && nbit_reg == `READ_HDR_BITS - 6'h1)
                        state_reg <= ST_READ;
                  end
               end
               ST_GAP: begin
                  // Select stays high for the full wake recovery time.
                  gap_reg <= gap_reg + 9'h1;
                  if (gap_reg == GAP_CYC - 9'h1) begin
                     sh_reg    <= {`CMD_FAST_READ, `READ_ADDR, 8'h00};
                     spi_mosi  <= 1'b0;
                     spi_cs_b  <= 1'b0;
                     nbit_reg  <= 6'h0;
                     state_reg <= ST_HDR;
                  end
               end
               ST_READ, ST_PASV, ST_JTAG: begin
                  if (all_in && !word_valid_reg)
                     state_reg <= ST_DONE;
               end
               ST_DONE: begin
                  // Release waits until the last word has left the buffer.
                  spi_oe    <= 1'b0;
                  spi_cs_b  <= 1'b1;
                  spi_clk_o <= 1'b0;
                  if (!cfg_mem_valid)
                     user_release <= 1'b1;
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Word assembly
   // ----------------------------------------
   // A finished word waits in asm_reg, flagged by word_valid_reg, until the buffer accepts it.
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         asm_reg        <= 32'h0;
         fill_reg       <= 6'h0;
         word_valid_reg <= 1'b0;
         words_in_reg   <= 16'h0;
         overrun_reg    <= 1'b0;
      end else if (state_reg == ST_IDLE) begin
         fill_reg       <= 6'h0;
         word_valid_reg <= 1'b0;
         words_in_reg   <= 16'h0;
         if (start)
            overrun_reg <= 1'b0;
      end else begin
         if (word_valid_reg && buf_ready) begin
            word_valid_reg <= 1'b0;
            words_in_reg   <= words_in_reg + 16'h1;
         end
         if (take && !all_in) begin
            asm_reg <= pack(asm_reg, take_bits, (state_reg == ST_PASV) ? wsel_reg : 3'd0);
            if (full_word) begin
               fill_reg       <= 6'h0;
               word_valid_reg <= 1'b1;
               // Passive and jtag sources cannot be held off.
               if (word_valid_reg && !buf_ready)
                  overrun_reg <= 1'b1;
            end else
               fill_reg <= fill_reg + wbits;
         end
      end
   end

   // ----------------------------------------
   // Two-entry buffer to configuration memory
   // ----------------------------------------
   reg [31:0] b1_reg;
   reg [1:0]  cnt_reg;
   wire       push = word_valid_reg & buf_ready;
   wire       pop  = cfg_mem_valid & cfg_mem_ready;
   assign buf_ready = (cnt_reg != 2'd2);

   // Head entry is the output register; the second entry backs it up.
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg       <= 2'd0;
         b1_reg        <= 32'h0;
         cfg_mem_data  <= 32'h0;
         cfg_mem_valid <= 1'b0;
         cfg_mem_addr  <= 16'h0;
      end else begin
         if (start)
            cfg_mem_addr <= 16'h0;
         else if (pop)
            cfg_mem_addr <= cfg_mem_addr + 16'h1;
         case ({push, pop})
            2'b10: begin
               if (cnt_reg == 2'd0)
                  cfg_mem_data <= asm_reg;
               else
                  b1_reg <= asm_reg;
               cnt_reg       <= cnt_reg + 2'd1;
               cfg_mem_valid <= 1'b1;
            end
            2'b01: begin
               cfg_mem_data  <= b1_reg;
               cnt_reg       <= cnt_reg - 2'd1;
               cfg_mem_valid <= (cnt_reg == 2'd2);
            end
            2'b11: begin
               if (cnt_reg == 2'd1)
                  cfg_mem_data <= asm_reg;
               else begin
                  cfg_mem_data <= b1_reg;
                  b1_reg       <= asm_reg;
               end
            end
            default: cnt_reg <= cnt_reg;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- rtl/config_loader_map.vh
/*
 Constants for the configuration loader: flash commands, timing, mode codes.
 Assumes inclusion by the loader with a 10 MHz core clock.
*/
`ifndef CONFIG_LOADER_MAP_VH
`define CONFIG_LOADER_MAP_VH
// ----------------------------------------
// Flash commands and field widths
// ----------------------------------------
`define CMD_WAKE       8'hab
`define CMD_FAST_READ  8'h0b
`define READ_ADDR      24'h000000
`define WAKE_BITS      6'd8
`define READ_HDR_BITS  6'd40
// ----------------------------------------
// Timing
// ----------------------------------------
`define CORE_CLK_MHZ   10
`define WAKE_GAP_US    30
`define WAKE_GAP_CYC   ((`WAKE_GAP_US * `CORE_CLK_MHZ))
`define SPI_HALF_CYC   4
// ----------------------------------------
// Mode codes and word width
// ----------------------------------------
`define MODE_ACTIVE    2'h0
`define MODE_PASSIVE   2'h1
`define MODE_JTAG      2'h2
`define WORD_BITS      32
`endif

//--- test/fpga_config_loader_assertions.sv
/*
 Pin-level checker for the configuration loader.
 Assumes binding to every loader instance; it sees the loader's ports only.
*/
`timescale 1ns/1ns
`default_nettype none
module fpga_config_loader_assertions (
   input wire logic        core_clk,             // Clock.
   input wire logic        rst_b,                // Reset.
   input wire logic        config_reset_low_pin, // Start pin.
   input wire logic        spi_clk_o,            // Flash clock.
   input wire logic        spi_cs_b,             // Select.
   input wire logic        spi_mosi,             // Data out.
   input wire logic        spi_oe,               // Pins driven.
   input wire logic [31:0] cfg_mem_data,         // Word.
   input wire logic [15:0] cfg_mem_addr,         // Address.
   input wire logic        cfg_mem_valid,        // Offered.
   input wire logic        cfg_mem_ready,        // Taken.
   input wire logic        overrun_reg,          // Word lost.
   input wire logic        user_release          // Released.
);
   // ----------------------------------------
   // Wake gap counter and properties
   // ----------------------------------------
   // Counts cycles with the select high while driven; a low select or idle pins clears it.
   logic [9:0] gap_reg;
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) gap_reg <= 10'h000;
      else gap_reg <= (spi_cs_b && spi_oe) ? gap_reg + 10'h001 : 10'h000;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_wake_gap_len: assert property ($fell(spi_cs_b) && $past(spi_oe) |-> gap_reg == 10'h12c)
      else $error("wake gap is not 300 cycles");
   a_wake_first_bit: assert property ($fell(spi_cs_b) && !$past(spi_oe) |-> spi_oe && spi_mosi)
      else $error("first frame does not open with the wake msb");
   a_clk_half_period: assert property ($changed(spi_clk_o) |=> $stable(spi_clk_o) [*3])
      else $error("flash clock half period too short");
   a_idle_pins_quiet: assert property (!spi_oe |-> spi_cs_b && !spi_clk_o)
      else $error("flash pins active while released");
   a_done_pins_free: assert property (user_release |-> !spi_oe && spi_cs_b)
      else $error("flash pins driven after release");
   a_hold_until_pin: assert property (!config_reset_low_pin [*5] |-> !user_release)
      else $error("user logic released with the pin low");
   a_word_held_stall: assert property (cfg_mem_valid && !cfg_mem_ready |=>
      overrun_reg || (cfg_mem_valid && $stable(cfg_mem_data) && $stable(cfg_mem_addr)))
      else $error("offered word changed before taken");
   a_addr_in_order: assert property (cfg_mem_valid && cfg_mem_ready ##1 cfg_mem_valid |->
      cfg_mem_addr == $past(cfg_mem_addr) + 16'h0001)
      else $error("word address not sequential");
endmodule
bind fpga_config_loader fpga_config_loader_assertions u_chk (.core_clk, .rst_b, .config_reset_low_pin,
   .spi_clk_o, .spi_cs_b, .spi_mosi, .spi_oe, .cfg_mem_data, .cfg_mem_addr, .cfg_mem_valid,
   .cfg_mem_ready, .overrun_reg, .user_release);
`default_nettype wire

//--- test/spi_flash_model.sv
/*
 Serial flash model: records the wake and read headers and returns the image.
 Assumes one active load per run, clocked entirely by the loader.
*/
`timescale 1ns/1ns
`default_nettype none
module spi_flash_model (
   input  wire logic        spi_clk_o, // Flash clock.
   input  wire logic        spi_cs_b,  // Select, active low.
   input  wire logic        spi_mosi,  // Data from loader.
   output var  logic        spi_miso,  // Data to loader.
   output var  logic [7:0]  wake_seen, // First frame.
   output var  logic [39:0] hdr_seen   // Second frame header.
);
   // ----------------------------------------
   // Frames and image
   // ----------------------------------------
   int          frames = 0;
   int          bits   = 0;
   logic [31:0] img;
   function automatic logic [31:0] pat(input int i);
      pat = 32'h3c5a0000 + i * 32'h00010f0f;
   endfunction
   initial begin
      spi_miso = 1'b0;
      wake_seen = 8'h00;
      hdr_seen = 40'h0;
   end
   // Each select fall opens a new frame.
   always @(negedge spi_cs_b) begin
      frames = frames + 1;
      bits = 0;
   end
   // Loader bits are taken on rising clock, msb first.
   always @(posedge spi_clk_o) if (!spi_cs_b) begin
      if (frames == 1) wake_seen = {wake_seen[6:0], spi_mosi};
      else if (bits < 40) hdr_seen = {hdr_seen[38:0], spi_mosi};
      bits = bits + 1;
   end
   // Image bits only follow a complete read header, launched on the falling clock.
   always @(negedge spi_clk_o) if (!spi_cs_b && frames == 2 && bits >= 40) begin
      img = pat((bits - 40) / 32);
      spi_miso <= img[31 - (bits - 40) % 32];
   end
   // A released line floats; flipping it keeps a stale bit from passing for data.
   always @(posedge spi_cs_b) spi_miso <= ~spi_miso;
endmodule
`default_nettype wire

//--- test/tb_fpga_config_loader.sv
/*
 Testbench for the configuration loader: passive, overrun, test port and flash loads.
 Assumes the loader, its map header and the flash model are compiled before it.
*/
`timescale 1ns/1ns
`include "config_loader_map.vh"
`default_nettype none
module tb_fpga_config_loader;
   // ----------------------------------------
   // Signals, loader, flash and memory sink
   // ----------------------------------------
   localparam int W = 4;
   logic core_clk = 1'b0, rst_b = 1'b0, config_reset_low_pin = 1'b0, spi_miso;
   logic [1:0] mode_pin = 2'h0;
   logic [2:0] width_pin = 3'h0;
   logic spi_clk_o, spi_cs_b, spi_mosi, spi_oe, cfg_mem_valid, overrun_reg, user_release;
   logic passive_clk = 1'b0, passive_cs_b = 1'b1, jtag_tck = 1'b0, jtag_tdi = 1'b0, jtag_load = 1'b0;
   logic [31:0] passive_data = 32'h0, cfg_mem_data;
   logic [15:0] cfg_mem_addr;
   logic cfg_mem_ready = 1'b1;
   logic [7:0] wake_seen;
   logic [39:0] hdr_seen;
   logic [31:0] got [0:15];
   int got_n = 0, num_errors = 0, tests_run = 0;
   fpga_config_loader #(.IMAGE_WORDS(W)) u_dut (.core_clk, .rst_b, .config_reset_low_pin, .mode_pin,
      .width_pin, .spi_clk_o, .spi_cs_b, .spi_mosi, .spi_oe, .spi_miso, .passive_clk, .passive_cs_b,
      .passive_data, .jtag_tck, .jtag_tdi, .jtag_load, .cfg_mem_data, .cfg_mem_addr, .cfg_mem_valid,
      .cfg_mem_ready, .overrun_reg, .user_release);
   spi_flash_model u_flash (.spi_clk_o, .spi_cs_b, .spi_mosi, .spi_miso, .wake_seen, .hdr_seen);
   // Clock, and a sink that records every word taken by its address.
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) if (cfg_mem_valid === 1'b1 && cfg_mem_ready) begin
      got[cfg_mem_addr[3:0]] <= cfg_mem_data;
      got_n <= got_n + 1;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Holds the pin low with the pins still idle, then lets it rise.
   task automatic start(input logic [1:0] m, input logic [2:0] w);
      mode_pin = m;
      width_pin = w;
      config_reset_low_pin = 1'b0;
      tick(6);
      got_n = 0;
      chk(spi_oe, 1'b0);
      config_reset_low_pin = 1'b1;
   endtask
   task automatic wait_rel(input int lim);
      for (int i = 0; i < lim && user_release !== 1'b1; i++) tick(1);
      chk(user_release, 1'b1);
   endtask
   task automatic chk_words;
      for (int i = 0; i < W; i++) chk(got[i], u_flash.pat(i));
      chk(32'(got_n), W);
   endtask
   // One 800 ns beat of a link clock with its data set half a period ahead.
   task automatic link_beat(input logic j, input logic [31:0] d);
      passive_data = d;
      jtag_tdi = d[0];
      #400;
      if (j) jtag_tck = 1'b1;
      else passive_clk = 1'b1;
      #400;
      jtag_tck = 1'b0;
      passive_clk = 1'b0;
   endtask
   task automatic test_passive;
      start(2'h1, 3'h7);
      passive_cs_b = 1'b0;
      for (int i = 0; i < W; i++) link_beat(1'b0, u_flash.pat(i));
      passive_cs_b = 1'b1;
      wait_rel(100);
      chk_words();
      chk(overrun_reg, 1'b0);
      $display("passive load finished");
   endtask
   task automatic test_overrun;
      cfg_mem_ready = 1'b0;
      start(2'h1, 3'h3);
      passive_cs_b = 1'b0;
      // Four byte-wide words: the fourth completes while the third still waits.
      for (int i = 0; i < 16; i++) link_beat(1'b0, u_flash.pat(i / 4) >> (24 - 8 * (i % 4)));
      passive_cs_b = 1'b1;
      tick(10);
      chk(overrun_reg, 1'b1);
      cfg_mem_ready = 1'b1;
      tick(20);
      chk(cfg_mem_valid, 1'b0);
      $display("overrun finished");
   endtask
   task automatic test_jtag;
      start(2'h2, 3'h3);
      jtag_load = 1'b1;
      for (int i = 0; i < W * 32; i++) link_beat(1'b1, u_flash.pat(i / 32) >> (31 - i % 32));
      jtag_load = 1'b0;
      wait_rel(100);
      chk_words();
      $display("test port load finished");
   endtask
   // The sink stalls long enough to fill the buffer; the flash clock must then freeze.
   task automatic test_active;
      logic held;
      cfg_mem_ready = 1'b0;
      start(2'h0, 3'h5);
      tick(1600);
      held = spi_clk_o;
      // An odd number of half periods, so a running clock would show the other level.
      tick(44);
      chk(spi_clk_o, held);
      cfg_mem_ready = 1'b1;
      wait_rel(4000);
      chk_words();
      chk(wake_seen, `CMD_WAKE);
      chk(hdr_seen[39:32], `CMD_FAST_READ);
      chk(hdr_seen[31:8], `READ_ADDR);
      chk(overrun_reg, 1'b0);
      $display("flash load finished");
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Main sequence and the watchdog that cuts a hang short.
   initial begin
      tick(16);
      rst_b = 1'b1;
      tick(2);
      test_passive();
      test_overrun();
      test_jtag();
      test_active();
      wrap_up();
   end
   initial begin
      #3000000;
      num_errors++;
      wrap_up();
   end
endmodule
`default_nettype wire
